/* File: hart_debug_control_status.sv */
// per-hart debug control and status register with debug mode entry/exit tracking.
// assumes the hart csr unit issues accesses and reports entry reasons and resume.
// Functional notes
// - version field reads 0 none, 4 conforming, 15 custom support
// - virtual-supervisor breakpoint bit set sends ebreak into debug mode
// - both virtual breakpoint bits read zero without virtualization
// - virtual-user breakpoint bit set sends ebreak into debug mode
// - machine breakpoint bit set enters debug mode; resets to zero
// - supervisor breakpoint bit enters debug mode; zero without supervisor mode
// - user breakpoint bit enters debug mode; zero without user mode
// - stepping with step-irq-enable zero blocks all interrupts including nmi
// - step-irq-enable may be tied to zero
// - counter freeze stops counters in debug mode and on entering ebreak; cycle_inhibit_o stays low unless SINGLE_HART is set
// - time freeze holds visible time from entry, tracks timer after exit
// - platform timer pauses only when all harts freeze time and halt
// - simultaneous entry reasons record the highest priority cause
// - cause codes: 1 breakpoint, 2 trigger, 3 halt request
// - cause codes: 4 step, 5 reset halt, 6 halt group
// - reset halt or group halt may report halt request code 3
// - virtualization mode captured on entry, writable for exit, else zero
// - modify-privilege enable bit gates mprv in debug mode; may be tied
// - pending-nmi bit reflects a pending nmi, resets to zero
// - step set outside debug mode runs one instruction then halts
// - privilege captured on entry, resets to 3, illegal writes legalized
// - priority: reset halt, group, halt request, trigger, ebreak, step
// - only the debugger writes fields other than captured and status ones
`timescale 1ns/1ps
module hart_debug_control_status #(
  parameter logic [3:0] DEBUG_VER       = hart_debug_pkg::VER_1_0,
  parameter bit         HAS_V           = 1'b1,
  parameter bit         HAS_S           = 1'b1,
  parameter bit         HAS_U           = 1'b1,
  parameter bit         STEPIE_WRITABLE = 1'b1,
  parameter bit         STOPCOUNT_WR    = 1'b1,
  parameter bit         STOPCOUNT_RST   = 1'b1,
  parameter bit         STOPTIME_WR     = 1'b1,
  parameter bit         STOPTIME_RST    = 1'b0,
  parameter bit         MPRVEN_WR       = 1'b1,
  parameter bit         MPRVEN_RST      = 1'b1,
  parameter bit         SINGLE_HART     = 1'b1,
  parameter bit         HALT_AS_REQ     = 1'b0,
  parameter int         TIME_W          = 64
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire hart_debug_pkg::csr_req_t   csr_req_i,
  input  wire hart_debug_pkg::entry_req_t entry_i,
  input  wire hart_debug_pkg::hart_mode_t cur_mode_i,
  input  wire logic                     resume_i,
  input  wire logic                     nmi_pending_i,
  input  wire logic [TIME_W-1:0]        mtime_i,
  output logic      [31:0]              csr_rdata_o,
  output logic                          csr_hit_o,
  output logic                          debug_mode_o,
  output hart_debug_pkg::hart_mode_t    resume_mode_o,
  output logic                          step_active_o,
  output logic                          irq_block_o,
  output logic                          ebreak_to_debug_o,
  output logic                          count_inhibit_o,
  output logic                          cycle_inhibit_o,
  output logic                          mprv_in_debug_o,
  output logic                          timer_pause_vote_o,
  output logic      [TIME_W-1:0]        time_o
);

  hart_debug_pkg::dbg_state_t state;
  hart_debug_pkg::dbg_state_t next_state;

  logic       ebreakvs;
  logic       ebreakvu;
  logic       ebreakm;
  logic       ebreaks;
  logic       ebreaku;
  logic       stepie;
  logic       stopcount;
  logic       stoptime;
  logic [2:0] cause;
  logic       v_bit;
  logic       mprven;
  logic       step;
  logic [1:0] prv;
  logic       nmi_sync1;
  logic       nmi_sync2;

  // access decode; writes land only while halted, i.e. from the debugger
  wire        halted    = (state == hart_debug_pkg::HALTED);
  wire        hit       = csr_req_i.valid
                          && (csr_req_i.addr == hart_debug_pkg::CTRL_STATUS_ADDR);
  wire        wr        = hit && csr_req_i.write && halted;
  wire [31:0] wd        = csr_req_i.wdata;
  // a step completion only counts as a reason while step is set
  wire hart_debug_pkg::entry_req_t reasons = '{
    resethalt: entry_i.resethalt, group: entry_i.group, haltreq: entry_i.haltreq,
    trigger: entry_i.trigger, ebreak: entry_i.ebreak, step: entry_i.step && step};
  wire        enter     = !halted && (|reasons);
  wire [2:0]  new_cause = hart_debug_pkg::pick_cause(reasons, HALT_AS_REQ);
  wire        leave     = halted && resume_i;

  // unsupported or reserved privilege resolves to machine mode
  wire [1:0]  wr_prv    = wd[hart_debug_pkg::PRV_LSB +: 2];
  wire        prv_ok    = (wr_prv == hart_debug_pkg::PRV_M)
                          || (wr_prv == hart_debug_pkg::PRV_S && HAS_S)
                          || (wr_prv == hart_debug_pkg::PRV_U && HAS_U);
  wire [1:0]  legal_prv = prv_ok ? wr_prv : hart_debug_pkg::PRV_M;

  // register image; version is a fixed parameter, unused bits read zero
  wire [31:0] reg_image  = {DEBUG_VER, 10'h000,
                            ebreakvs, ebreakvu, ebreakm, 1'b0, ebreaks, ebreaku,
                            stepie, stopcount, stoptime, cause, v_bit, mprven,
                            nmi_sync2, step, prv};

  // breakpoint routing for the mode the hart currently runs in
  wire ebreak_dm = cur_mode_i.v
                   ? ((cur_mode_i.prv == hart_debug_pkg::PRV_S) ? ebreakvs : ebreakvu)
                   : ((cur_mode_i.prv == hart_debug_pkg::PRV_M) ? ebreakm
                     : (cur_mode_i.prv == hart_debug_pkg::PRV_S) ? ebreaks : ebreaku);

  // run/halt state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      hart_debug_pkg::RUNNING: if (enter) next_state = hart_debug_pkg::HALTED;
      hart_debug_pkg::HALTED:  if (resume_i) next_state = hart_debug_pkg::RUNNING;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= hart_debug_pkg::RUNNING;
    end else begin
      state <= next_state;
    end
  end

  // nmi pending, two-stage synchroniser; stage two is the readable bit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_sync1 <= 1'b0;
      nmi_sync2 <= 1'b0;
    end else begin
      nmi_sync1 <= nmi_pending_i;
      nmi_sync2 <= nmi_sync1;
    end
  end

  // virtual breakpoint bits, tied low without virtualization
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ebreakvs <= hart_debug_pkg::RST_BIT;
      ebreakvu <= hart_debug_pkg::RST_BIT;
    end else if (wr) begin
      ebreakvs <= HAS_V && wd[hart_debug_pkg::EBREAKVS_BIT];
      ebreakvu <= HAS_V && wd[hart_debug_pkg::EBREAKVU_BIT];
    end
  end

  // breakpoint bits; missing modes keep the bit at zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ebreakm <= hart_debug_pkg::RST_BIT;
      ebreaks <= hart_debug_pkg::RST_BIT;
      ebreaku <= hart_debug_pkg::RST_BIT;
    end else if (wr) begin
      ebreakm <= wd[hart_debug_pkg::EBREAKM_BIT];
      ebreaks <= HAS_S && wd[hart_debug_pkg::EBREAKS_BIT];
      ebreaku <= HAS_U && wd[hart_debug_pkg::EBREAKU_BIT];
    end
  end

  // step controls change only on halted writes; stepie may be tied low
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stepie <= hart_debug_pkg::RST_BIT;
      step   <= hart_debug_pkg::RST_BIT;
    end else if (wr) begin
      stepie <= STEPIE_WRITABLE && wd[hart_debug_pkg::STEPIE_BIT];
      step   <= wd[hart_debug_pkg::STEP_BIT];
    end
  end

  // preset fields; a non-writable one keeps its preset forever
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stopcount <= STOPCOUNT_RST;
      stoptime  <= STOPTIME_RST;
      mprven    <= MPRVEN_RST;
    end else if (wr) begin
      if (STOPCOUNT_WR) stopcount <= wd[hart_debug_pkg::STOPCOUNT_BIT];
      if (STOPTIME_WR) stoptime <= wd[hart_debug_pkg::STOPTIME_BIT];
      if (MPRVEN_WR) mprven <= wd[hart_debug_pkg::MPRVEN_BIT];
    end
  end

  // entry capture; cause is read-only to software
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause <= hart_debug_pkg::RST_CAUSE;
      v_bit <= hart_debug_pkg::RST_V;
      prv   <= hart_debug_pkg::RST_PRV;
    end else if (enter) begin
      cause <= new_cause;
      v_bit <= HAS_V && cur_mode_i.v;
      prv   <= cur_mode_i.prv;
    end else if (wr) begin
      v_bit <= HAS_V && wd[hart_debug_pkg::V_BIT];
      prv   <= legal_prv;
    end
  end

  // csr read data; reads work in any state, the core decides legality
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      csr_rdata_o <= 32'h00000000;
      csr_hit_o   <= 1'b0;
    end else begin
      csr_rdata_o <= hit ? reg_image : 32'h00000000;
      csr_hit_o   <= hit;
    end
  end

  // control outputs, registered; run/halt-dependent ones from next state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      debug_mode_o       <= 1'b0;
      resume_mode_o      <= '{v: hart_debug_pkg::RST_V, prv: hart_debug_pkg::RST_PRV};
      step_active_o      <= 1'b0;
      irq_block_o        <= 1'b0;
      ebreak_to_debug_o  <= 1'b0;
      count_inhibit_o    <= 1'b0;
      cycle_inhibit_o    <= 1'b0;
      mprv_in_debug_o    <= 1'b0;
      timer_pause_vote_o <= 1'b0;
    end else begin
      debug_mode_o       <= (next_state == hart_debug_pkg::HALTED);
      resume_mode_o      <= '{v: v_bit, prv: prv};
      step_active_o      <= (next_state == hart_debug_pkg::RUNNING) && step;
      // interrupts and nmi are held off while stepping unless enabled
      irq_block_o        <= (next_state == hart_debug_pkg::RUNNING) && step && !stepie;
      ebreak_to_debug_o  <= ebreak_dm;
      // counters freeze in debug mode and on the ebreak that enters it
      count_inhibit_o    <= stopcount && ((next_state == hart_debug_pkg::HALTED)
                                          || (enter && new_cause == hart_debug_pkg::CAUSE_EBREAK));
      // multi-hart cores keep cycle running for the other harts
      cycle_inhibit_o    <= SINGLE_HART && stopcount
                            && (next_state == hart_debug_pkg::HALTED);
      mprv_in_debug_o    <= mprven;
      // this hart's consent only; the platform must and all harts' votes
      timer_pause_vote_o <= stoptime && (next_state == hart_debug_pkg::HALTED);
    end
  end

  debug_time_hold #(
    .TIME_W    (TIME_W)
  ) u_time_hold (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .freeze_i  (stoptime && halted),
    .mtime_i   (mtime_i),
    .time_o    (time_o)
  );

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_version_value: assert property (
    csr_hit_o |-> csr_rdata_o[31:28] == DEBUG_VER
  ) else $error("version field wrong");

  a_virt_bits_tied: assert property (
    wr |=> (ebreakvs == (HAS_V && $past(wd[hart_debug_pkg::EBREAKVS_BIT])))
           && (ebreakvu == (HAS_V && $past(wd[hart_debug_pkg::EBREAKVU_BIT])))
           && (HAS_V || !v_bit)
  ) else $error("virtual bits not zero");

  a_entry_halts: assert property (
    enter |=> debug_mode_o && (cause == $past(new_cause))
  ) else $error("entry not captured");

  a_reset_halt_prio: assert property (
    (enter && entry_i.resethalt) |=> cause == (HALT_AS_REQ ? hart_debug_pkg::CAUSE_HALTREQ
                                             : hart_debug_pkg::CAUSE_RSTHALT)
  ) else $error("reset halt priority wrong");

  a_step_lowest: assert property (
    (enter && reasons.step && reasons.ebreak) |=> cause == hart_debug_pkg::CAUSE_EBREAK
  ) else $error("step outranked ebreak");

  a_prv_capture: assert property (
    enter |=> prv == $past(cur_mode_i.prv)
  ) else $error("privilege not captured");

  a_irq_block_step: assert property (
    (!halted && !enter && step && !stepie) |=> irq_block_o
  ) else $error("interrupts not blocked while stepping");

  a_run_no_write: assert property (
    (!halted && hit && csr_req_i.write) |=> $stable(step) && $stable(ebreakm)
  ) else $error("write accepted while running");

  a_nmip_follow: assert property (
    ##2 nmi_sync2 == $past(nmi_pending_i, 2)
  ) else $error("nmip does not follow nmi");

  a_time_frozen: assert property (
    (stoptime && halted) [*2] |=> $stable(time_o)
  ) else $error("time moved while frozen");

  a_count_freeze: assert property (
    (halted && !resume_i && stopcount) |=> count_inhibit_o
  ) else $error("counters not frozen");

  c_ebreak_entry: cover property (enter && new_cause == hart_debug_pkg::CAUSE_EBREAK);
  c_step_entry:   cover property (enter && new_cause == hart_debug_pkg::CAUSE_STEP);
  c_resume:       cover property (leave ##1 !debug_mode_o);
  c_time_hold:    cover property ((stoptime && halted) [*3]);

endmodule

/* File: hart_debug_pkg.sv */
// package for the per-hart debug control and status register block.
// assumes a single hart clock; shared by the register logic, the debugger model and the bench.
package hart_debug_pkg;

  // csr address of the control and status register
  localparam logic [11:0] CTRL_STATUS_ADDR = 12'h7B0;

  // field positions inside the 32-bit register
  localparam int          DEBUGVER_LSB  = 28;
  localparam int          EBREAKVS_BIT  = 17;
  localparam int          EBREAKVU_BIT  = 16;
  localparam int          EBREAKM_BIT   = 15;
  localparam int          EBREAKS_BIT   = 13;
  localparam int          EBREAKU_BIT   = 12;
  localparam int          STEPIE_BIT    = 11;
  localparam int          STOPCOUNT_BIT = 10;
  localparam int          STOPTIME_BIT  = 9;
  localparam int          CAUSE_LSB     = 6;
  localparam int          V_BIT         = 5;
  localparam int          MPRVEN_BIT    = 4;
  localparam int          NMIP_BIT      = 3;
  localparam int          STEP_BIT      = 2;
  localparam int          PRV_LSB       = 0;

  // version codes
  localparam logic [3:0]  VER_NONE      = 4'h0;
  localparam logic [3:0]  VER_1_0       = 4'h4;
  localparam logic [3:0]  VER_CUSTOM    = 4'hF;

  // entry cause codes
  localparam logic [2:0]  CAUSE_NONE    = 3'h0;
  localparam logic [2:0]  CAUSE_EBREAK  = 3'h1;
  localparam logic [2:0]  CAUSE_TRIGGER = 3'h2;
  localparam logic [2:0]  CAUSE_HALTREQ = 3'h3;
  localparam logic [2:0]  CAUSE_STEP    = 3'h4;
  localparam logic [2:0]  CAUSE_RSTHALT = 3'h5;
  localparam logic [2:0]  CAUSE_GROUP   = 3'h6;

  // privilege encodings
  localparam logic [1:0]  PRV_U         = 2'h0;
  localparam logic [1:0]  PRV_S         = 2'h1;
  localparam logic [1:0]  PRV_RSVD      = 2'h2;
  localparam logic [1:0]  PRV_M         = 2'h3;

  // reset values of captured fields and of the debugger-owned bits
  localparam logic [1:0]  RST_PRV       = PRV_M;
  localparam logic        RST_V         = 1'b0;
  localparam logic [2:0]  RST_CAUSE     = CAUSE_NONE;
  localparam logic        RST_BIT       = 1'b0;

  typedef enum logic {RUNNING, HALTED} dbg_state_t;

  // csr access from the hart's csr unit
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_t;

  // debug entry reasons raised by the hart in one cycle
  typedef struct packed {
    logic resethalt;
    logic group;
    logic haltreq;
    logic trigger;
    logic ebreak;
    logic step;
  } entry_req_t;

  // privilege and virtualization mode
  typedef struct packed {
    logic       v;
    logic [1:0] prv;
  } hart_mode_t;

  // highest-priority cause among simultaneous reasons
  function automatic logic [2:0] pick_cause(input entry_req_t e, input logic halt_as_req);
    logic [2:0] c;
    c = CAUSE_NONE;
    if (e.resethalt) begin
      c = halt_as_req ? CAUSE_HALTREQ : CAUSE_RSTHALT;
    end else if (e.group) begin
      c = halt_as_req ? CAUSE_HALTREQ : CAUSE_GROUP;
    end else if (e.haltreq) begin
      c = CAUSE_HALTREQ;
    end else if (e.trigger) begin
      c = CAUSE_TRIGGER;
    end else if (e.ebreak) begin
      c = CAUSE_EBREAK;
    end else if (e.step) begin
      c = CAUSE_STEP;
    end
    return c;
  endfunction

endpackage

/* File: debug_time_hold.sv */
// holds the hart-visible time value while frozen in debug mode.
// assumes the platform timer value is on the same clock as the hart.
`timescale 1ns/1ps
module debug_time_hold #(
  parameter int TIME_W = 64
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              freeze_i,
  input  wire logic [TIME_W-1:0] mtime_i,
  output logic      [TIME_W-1:0] time_o
);

  // follow the platform timer unless frozen; the held value is the last one before freeze
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      time_o <= '0;
    end else if (!freeze_i) begin
      time_o <= mtime_i;
    end
  end

endmodule

/* File: debug_host_model.sv */
// debugger model: issues accesses to the hart debug register.
// assumes the bench clock and no access before reset is released.
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic                     ref_clk_i,
  input  wire logic                     halted_i,
  input  wire logic [31:0]              rdata_i,
  input  wire logic                     hit_i,
  output hart_debug_pkg::csr_req_t      csr_req_o
);
  logic [31:0] last_rdata;
  logic        last_hit;

  // bus idle at time zero
  initial begin
    csr_req_o = '0;
  end

  // one access held over its sampling edge; idle bus carries inverted data, never stale
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge ref_clk_i);
    #1;
    csr_req_o = {1'b1, wr, addr, wd};
    @(posedge ref_clk_i);
    #1;
    csr_req_o = {1'b0, 1'b0, ~addr, ~wd};
    last_rdata = rdata_i;
    last_hit = hit_i;
  endtask

  task automatic write(input logic [31:0] wd, input logic rogue);
    if (halted_i || rogue) begin
      access(1'b1, hart_debug_pkg::CTRL_STATUS_ADDR, wd);
    end
  endtask

  task automatic read(output logic [31:0] rd);
    access(1'b0, hart_debug_pkg::CTRL_STATUS_ADDR, 32'h0000_0000);
    rd = last_rdata;
  endtask
endmodule

/* File: hart_debug_control_status_tb.sv */
// self-checking bench for the hart debug control and status register.
// assumes default design parameters: version 4, stopcount and mprven preset to 1.
`timescale 1ns/1ps
module hart_debug_control_status_tb;
  localparam logic [31:0] RST_VAL = 32'h4000_0413;
  logic                       ref_clk_i = 1'b0;
  logic                       rst_i     = 1'b1;
  hart_debug_pkg::csr_req_t   csr_req;
  hart_debug_pkg::entry_req_t entry     = '0;
  hart_debug_pkg::hart_mode_t cur_mode  = 3'h3;
  hart_debug_pkg::hart_mode_t res_mode;
  logic                       resume    = 1'b0;
  logic                       nmi       = 1'b0;
  logic [63:0]                mtime     = 64'h0;
  logic [63:0]                time_v;
  logic [31:0]                rdata;
  logic                       hit, dbg_mode, step_act, irq_blk, eb_dbg;
  logic                       cnt_inh, cyc_inh, mprv, vote;
  int                         err_count = 0;
  int                         cmp_count = 0;

  always #5 ref_clk_i = ~ref_clk_i;
  // platform timer keeps counting
  always @(posedge ref_clk_i) mtime <= mtime + 64'h1;

  hart_debug_control_status uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .csr_req_i(csr_req), .entry_i(entry),
    .cur_mode_i(cur_mode), .resume_i(resume), .nmi_pending_i(nmi), .mtime_i(mtime),
    .csr_rdata_o(rdata), .csr_hit_o(hit), .debug_mode_o(dbg_mode),
    .resume_mode_o(res_mode), .step_active_o(step_act), .irq_block_o(irq_blk),
    .ebreak_to_debug_o(eb_dbg), .count_inhibit_o(cnt_inh), .cycle_inhibit_o(cyc_inh),
    .mprv_in_debug_o(mprv), .timer_pause_vote_o(vote), .time_o(time_v));

  debug_host_model dbg (
    .ref_clk_i(ref_clk_i), .halted_i(dbg_mode), .rdata_i(rdata), .hit_i(hit),
    .csr_req_o(csr_req));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle entry pulse with the hart mode at that moment
  task automatic enter(input logic [5:0] e, input logic [2:0] m);
    @(posedge ref_clk_i);
    #1;
    entry = e;
    cur_mode = m;
    @(posedge ref_clk_i);
    #1;
    entry = '0;
  endtask

  task automatic leave;
    @(posedge ref_clk_i);
    #1;
    resume = 1'b1;
    @(posedge ref_clk_i);
    #1;
    resume = 1'b0;
  endtask

  task automatic t_reset;
    logic [31:0] v;
    dbg.read(v);
    check(v, RST_VAL);
    check(res_mode, 3'h3);
    dbg.access(1'b0, 12'h7B1, 32'h0000_0000);
    check({dbg.last_hit, dbg.last_rdata}, 33'h0);
    dbg.write(32'hFFFF_FFFF, 1'b1);
    check(dbg.last_hit, 1'b1);
    dbg.read(v);
    check(v, RST_VAL);
  endtask

  // each cause above step with every lower-priority reason stacked under it
  task automatic t_priority;
    logic [5:0]  vec [5] = '{6'h3F, 6'h1F, 6'h0F, 6'h07, 6'h03};
    logic [2:0]  cz  [5] = '{3'h5, 3'h6, 3'h3, 3'h2, 3'h1};
    logic [31:0] v;
    for (int i = 0; i < 5; i++) begin
      enter(vec[i], 3'h3);
      check(dbg_mode, 1'b1);
      check({cnt_inh, cyc_inh}, 2'h3);
      dbg.read(v);
      check(v[8:6], cz[i]);
      leave();
      check(dbg_mode, 1'b0);
    end
  endtask

  // capture of the mode, legalised privilege, each breakpoint enable
  task automatic t_modes;
    logic [31:0] bits [5] = '{32'h2_0000, 32'h1_0000, 32'h8000, 32'h2000, 32'h1000};
    logic [2:0]  md   [5] = '{3'h5, 3'h4, 3'h3, 3'h1, 3'h0};
    logic [31:0] v;
    enter(6'h08, 3'h5);
    dbg.read(v);
    check(v[5:0], 6'h31);
    dbg.write(32'h0002_0002, 1'b0);
    dbg.read(v);
    check(v, 32'h4002_00C3);
    check({res_mode, mprv}, 4'h6);
    for (int i = 0; i < 5; i++) begin
      dbg.write(bits[i] | 32'h3, 1'b0);
      cur_mode = md[i];
      repeat (2) @(posedge ref_clk_i);
      #1;
      check(eb_dbg, 1'b1);
      cur_mode = md[(i + 1) % 5];
      repeat (2) @(posedge ref_clk_i);
      #1;
      check(eb_dbg, 1'b0);
    end
  endtask

  task automatic t_step;
    logic [31:0] v;
    dbg.write(32'h0000_0007, 1'b0);
    leave();
    check({step_act, irq_blk}, 2'h3);
    enter(6'h01, 3'h3);
    dbg.read(v);
    check({dbg_mode, v[8:6]}, 4'hC);
    dbg.write(32'h0000_0807, 1'b0);
    leave();
    check({step_act, irq_blk}, 2'h2);
    enter(6'h01, 3'h3);
    dbg.write(32'h0000_0003, 1'b0);
    leave();
    enter(6'h01, 3'h3);
    check(dbg_mode, 1'b0);
    enter(6'h08, 3'h3);
  endtask

  task automatic t_time;
    logic [63:0] held;
    logic [31:0] v;
    dbg.write(32'h0000_0203, 1'b0);
    repeat (2) @(posedge ref_clk_i);
    #1;
    held = time_v;
    repeat (3) @(posedge ref_clk_i);
    #1;
    check(time_v, held);
    check(vote, 1'b1);
    leave();
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(time_v, mtime - 64'h1);
    check(vote, 1'b0);
    nmi = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    dbg.read(v);
    check(v[3], 1'b1);
    nmi = 1'b0;
  endtask

  // watchdog well past the expected run length
  initial begin
    #200000;
    err_count++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_priority();
    t_modes();
    t_step();
    t_time();
    final_report();
  end
endmodule
